// ===== logic/bal_consts.svh
// Named constants of the byte ALU execution unit
`ifndef BAL_CONSTS_SVH
`define BAL_CONSTS_SVH
`define BAL_LEN_ONE    2'h1
`define BAL_LEN_TWO    2'h2
`define BAL_LEN_THREE  2'h3
`define BAL_CYC_ONE    3'h1
`define BAL_CYC_TWO    3'h2
`define BAL_CYC_FOUR   3'h4
`define BAL_BYTE_RST   8'h00
`define BAL_PTR_RST    16'h0000
`define BAL_BYTE_STEP  8'h01
`define BAL_PTR_STEP   16'h0001
`define BAL_BCD_LIMIT  4'h9
`define BAL_BCD_FIX_LO 9'h006
`define BAL_BCD_FIX_HI 9'h060
`endif

// ===== logic/bal_pkg.sv
// Types shared by the byte ALU execution unit
package bal_pkg;
   typedef enum logic [3:0] {BAL_OP_ADD, BAL_OP_ADD_WITH_CARRY_OP, BAL_OP_SUBTRACT_WITH_BORROW_OP, BAL_OP_AND, BAL_OP_OR,
                             BAL_OP_XOR, BAL_OP_INC, BAL_OP_DEC, BAL_OP_INC_PTR,
                             BAL_OP_MUL, BAL_OP_DIV, BAL_OP_BCD} bal_op_t;
   // Operand form: source for accumulator forms, destination for the direct forms
   typedef enum logic [2:0] {BAL_F_REG, BAL_F_DIR, BAL_F_IND, BAL_F_IMM, BAL_F_ACC,
                             BAL_F_DIR_ACC, BAL_F_DIR_IMM} bal_form_t;
   typedef enum logic {BAL_IDLE, BAL_BUSY} bal_phase_t;
   typedef struct packed {
      bal_op_t   op;
      bal_form_t form;
      logic [7:0] addr;
      logic [7:0] src;
      logic [7:0] imm;
   } bal_cmd_t;
   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } bal_wr_t;
   typedef struct packed {
      bal_phase_t  phase;
      logic [2:0]  cnt;
      bal_cmd_t    held;
      logic [7:0]  acc;
      logic [7:0]  b;
      logic        cy;
      logic        ac;
      logic        ov;
      logic [15:0] ptr;
      logic        done;
      logic [1:0]  len;
      bal_wr_t     wr;
   } bal_state_t;
endpackage

// ===== logic/bal_exec.sv
// Byte ALU execution unit: arithmetic, logic, multiply, divide and BCD correction
//
// Contract
// - Add register or indirect: one byte, one cycle
// - Add direct or immediate: two bytes, one cycle
// - Add with carry sums carry; register one byte
// - Add with carry direct/immediate two bytes, indirect one
// - Subtract with borrow into accumulator; direct two bytes
// - Subtract register or indirect: one byte, one cycle
// - AND into accumulator: one cycle, one/two bytes
// - AND accumulator into direct byte: two bytes
// - AND immediate into direct: three bytes, two cycles
// - OR into accumulator: one cycle, one/two bytes
// - OR accumulator into direct byte: two bytes
// - OR immediate into direct: three bytes, two cycles
// - XOR into accumulator: one cycle, one/two bytes
`timescale 1ns/1ps
`include "bal_consts.svh"
module bal_exec
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // Command from the decoder
   input  wire logic             cmd_valid,
   output logic                  cmd_ready,
   input  wire bal_pkg::bal_cmd_t cmd_i,
   // Completion
   output logic                  done_o,
   output logic [1:0]            len_o,
   // Write to a direct-addressed byte
   output bal_pkg::bal_wr_t      wr_o,
   // Architectural state
   output logic [7:0]            acc_o,
   output logic [7:0]            b_o,
   output logic                  cy_o,
   output logic                  ac_o,
   output logic                  ov_o,
   output logic [15:0]           ptr_o
);
   bal_pkg::bal_state_t s_q;
   bal_pkg::bal_state_t s_d;
   logic                accept;

   function automatic logic [1:0] len_of(input bal_pkg::bal_cmd_t c);
      logic [1:0] l;
      l = `BAL_LEN_ONE;
      if (c.op inside {bal_pkg::BAL_OP_MUL, bal_pkg::BAL_OP_DIV, bal_pkg::BAL_OP_BCD,
                       bal_pkg::BAL_OP_INC_PTR})
      begin
         l = `BAL_LEN_ONE;
      end
      else if (c.form == bal_pkg::BAL_F_DIR_IMM)
      begin
         l = `BAL_LEN_THREE;
      end
      else if (c.form inside {bal_pkg::BAL_F_DIR, bal_pkg::BAL_F_IMM, bal_pkg::BAL_F_DIR_ACC})
      begin
         l = `BAL_LEN_TWO;
      end
      return l;
   endfunction

   // Machine cycles an instruction takes
   function automatic logic [2:0] cyc_of(input bal_pkg::bal_cmd_t c);
      logic [2:0] n;
      n = `BAL_CYC_ONE;
      if (c.op inside {bal_pkg::BAL_OP_MUL, bal_pkg::BAL_OP_DIV})
      begin
         n = `BAL_CYC_FOUR;
      end
      else if (c.op == bal_pkg::BAL_OP_INC_PTR)
      begin
         n = `BAL_CYC_TWO;
      end
      else if (c.form == bal_pkg::BAL_F_DIR_IMM)
      begin
         n = `BAL_CYC_TWO;
      end
      return n;
   endfunction

   // Final cycle of an instruction: compute result, flags and write-back
   function automatic bal_pkg::bal_state_t apply(input bal_pkg::bal_state_t s,
                                                 input bal_pkg::bal_cmd_t   c);
      bal_pkg::bal_state_t r;
      logic [7:0]  x;
      logic [7:0]  y;
      logic [7:0]  res;
      logic        cin;
      logic        to_dir;
      logic [4:0]  lo;
      logic [8:0]  full;
      logic [15:0] prod;
      r      = s;
      x      = (c.form == bal_pkg::BAL_F_DIR_IMM) ? c.src : s.acc;
      y      = (c.form inside {bal_pkg::BAL_F_IMM, bal_pkg::BAL_F_DIR_IMM}) ? c.imm : c.src;
      res    = s.acc;
      cin    = (c.op == bal_pkg::BAL_OP_ADD) ? 1'b0 : s.cy;
      to_dir = c.form inside {bal_pkg::BAL_F_DIR_ACC, bal_pkg::BAL_F_DIR_IMM};
      lo     = '0;
      full   = '0;
      prod   = '0;
      case (c.op)
         // add, carry-in only for add with carry
         bal_pkg::BAL_OP_ADD, bal_pkg::BAL_OP_ADD_WITH_CARRY_OP:
         begin
            lo   = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
            full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
            res  = full[7:0];
            r.cy = full[8];
            r.ac = lo[4];
            r.ov = (x[7] == y[7]) && (full[7] != x[7]);
         end
         // difference less borrow stays in the accumulator
         bal_pkg::BAL_OP_SUBTRACT_WITH_BORROW_OP:
         begin
            lo   = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
            full = {1'b0, x} - {1'b0, y} - {8'h00, cin};
            res  = full[7:0];
            r.cy = full[8];
            r.ac = lo[4];
            r.ov = (x[7] != y[7]) && (full[7] != x[7]);
         end
         bal_pkg::BAL_OP_AND: res = x & y;
         bal_pkg::BAL_OP_OR:  res = x | y;
         bal_pkg::BAL_OP_XOR: res = x ^ y;
         bal_pkg::BAL_OP_INC, bal_pkg::BAL_OP_DEC:
         begin
            x      = (c.form == bal_pkg::BAL_F_ACC) ? s.acc : c.src;
            res    = (c.op == bal_pkg::BAL_OP_INC) ? x + `BAL_BYTE_STEP : x - `BAL_BYTE_STEP;
            to_dir = (c.form != bal_pkg::BAL_F_ACC);
         end
         bal_pkg::BAL_OP_INC_PTR: r.ptr = s.ptr + `BAL_PTR_STEP;
         // product low byte to accumulator, high byte to B
         bal_pkg::BAL_OP_MUL:
         begin
            prod  = {8'h00, s.acc} * {8'h00, s.b};
            res   = prod[7:0];
            r.b   = prod[15:8];
            r.cy  = 1'b0;
            r.ov  = |prod[15:8];
         end
         // quotient to accumulator, remainder to B; zero divisor flags overflow
         bal_pkg::BAL_OP_DIV:
         begin
            r.cy = 1'b0;
            r.ov = (s.b == `BAL_BYTE_RST);
            if (s.b != `BAL_BYTE_RST)
            begin
               res = s.acc / s.b;
               r.b = s.acc % s.b;
            end
         end
         // decimal correction after a binary add
         bal_pkg::BAL_OP_BCD:
         begin
            full = {1'b0, s.acc};
            if (s.ac || (s.acc[3:0] > `BAL_BCD_LIMIT))
            begin
               full = full + `BAL_BCD_FIX_LO;
            end
            cin = s.cy | full[8];
            if (cin || (full[7:4] > `BAL_BCD_LIMIT))
            begin
               full = {1'b0, full[7:0]} + `BAL_BCD_FIX_HI;
               cin  = cin | full[8];
            end
            res  = full[7:0];
            r.cy = cin;
         end
         default: res = s.acc;
      endcase
      // direct forms write memory, not the accumulator
      if (to_dir)
      begin
         r.wr.en   = 1'b1;
         r.wr.addr = c.addr;
         r.wr.data = res;
      end
      else if (c.op != bal_pkg::BAL_OP_INC_PTR)
      begin
         r.acc = res;
      end
      r.done  = 1'b1;
      r.len   = len_of(c);
      r.phase = bal_pkg::BAL_IDLE;
      r.cnt   = '0;
      return r;
   endfunction
   // Ready whenever no multi-cycle instruction is in flight
   assign cmd_ready = (s_q.phase == bal_pkg::BAL_IDLE);
   assign accept    = cmd_valid && cmd_ready;

   // Next state: one-cycle ops finish at once, longer ones count down
   always_comb
   begin
      s_d       = s_q;
      s_d.done  = 1'b0;
      s_d.wr.en = 1'b0;
      case (s_q.phase)
         bal_pkg::BAL_IDLE:
         begin
            if (accept && (cyc_of(cmd_i) == `BAL_CYC_ONE))
            begin
               s_d = apply(s_d, cmd_i);
            end
            else if (accept)
            begin
               s_d.phase = bal_pkg::BAL_BUSY;
               s_d.cnt   = cyc_of(cmd_i) - `BAL_CYC_ONE;
               s_d.held  = cmd_i;
            end
         end
         bal_pkg::BAL_BUSY:
         begin
            if (s_q.cnt == `BAL_CYC_ONE)
            begin
               s_d = apply(s_d, s_q.held);
            end
            else
            begin
               s_d.cnt = s_q.cnt - `BAL_CYC_ONE;
            end
         end
         default: s_d.phase = bal_pkg::BAL_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q       <= '0;
         s_q.phase <= bal_pkg::BAL_IDLE;
         s_q.acc   <= `BAL_BYTE_RST;
         s_q.b     <= `BAL_BYTE_RST;
         s_q.ptr   <= `BAL_PTR_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign done_o = s_q.done;
   assign len_o  = s_q.len;
   assign wr_o   = s_q.wr;
   assign acc_o  = s_q.acc;
   assign b_o    = s_q.b;
   assign cy_o   = s_q.cy;
   assign ac_o   = s_q.ac;
   assign ov_o   = s_q.ov;
   assign ptr_o  = s_q.ptr;

   // Checks on completion timing, lengths and results
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   add_short_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_ADD &&
      cmd_i.form inside {bal_pkg::BAL_F_REG, bal_pkg::BAL_F_IND}
      |=> done_o && len_o == `BAL_LEN_ONE && acc_o == $past(8'(acc_o + cmd_i.src)))
      else $error("add from register or indirect wrong");
   add_long_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_ADD &&
      cmd_i.form inside {bal_pkg::BAL_F_DIR, bal_pkg::BAL_F_IMM}
      |=> done_o && len_o == `BAL_LEN_TWO)
      else $error("add direct or immediate wrong length or timing");
   add_with_carry_op_sum_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_ADD_WITH_CARRY_OP &&
      cmd_i.form == bal_pkg::BAL_F_REG
      |=> done_o && len_o == `BAL_LEN_ONE && acc_o == $past(8'(acc_o + cmd_i.src + {7'h00, cy_o})))
      else $error("add with carry sum wrong");
   add_with_carry_op_len_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_ADD_WITH_CARRY_OP &&
      cmd_i.form != bal_pkg::BAL_F_REG
      |=> done_o && len_o == ($past(cmd_i.form) == bal_pkg::BAL_F_IND ? `BAL_LEN_ONE : `BAL_LEN_TWO))
      else $error("add with carry length wrong");
   subtract_with_borrow_op_dir_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_SUBTRACT_WITH_BORROW_OP &&
      cmd_i.form == bal_pkg::BAL_F_DIR
      |=> len_o == `BAL_LEN_TWO && acc_o == $past(8'(acc_o - cmd_i.src - {7'h00, cy_o})))
      else $error("subtract with borrow wrong");
   subtract_with_borrow_op_short_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_SUBTRACT_WITH_BORROW_OP &&
      cmd_i.form inside {bal_pkg::BAL_F_REG, bal_pkg::BAL_F_IND}
      |=> done_o && len_o == `BAL_LEN_ONE && !wr_o.en)
      else $error("short subtract wrong");
   and_acc_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_AND &&
      cmd_i.form == bal_pkg::BAL_F_IMM
      |=> done_o && len_o == `BAL_LEN_TWO && acc_o == $past(acc_o & cmd_i.imm))
      else $error("and into accumulator wrong");
   and_dir_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_AND &&
      cmd_i.form == bal_pkg::BAL_F_DIR_ACC
      |=> wr_o.en && wr_o.data == $past(acc_o & cmd_i.src) && wr_o.addr == $past(cmd_i.addr)
          && acc_o == $past(acc_o) && len_o == `BAL_LEN_TWO)
      else $error("and into direct byte wrong");
   and_dir_imm_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_AND &&
      cmd_i.form == bal_pkg::BAL_F_DIR_IMM
      |=> !done_o && !cmd_ready ##1 done_o && wr_o.en && len_o == `BAL_LEN_THREE)
      else $error("and immediate into direct timing wrong");
   or_acc_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_OR &&
      cmd_i.form == bal_pkg::BAL_F_REG
      |=> done_o && len_o == `BAL_LEN_ONE && acc_o == $past(acc_o | cmd_i.src))
      else $error("or into accumulator wrong");
   or_dir_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_OR &&
      cmd_i.form == bal_pkg::BAL_F_DIR_ACC
      |=> done_o && wr_o.en && wr_o.data == $past(acc_o | cmd_i.src) && len_o == `BAL_LEN_TWO)
      else $error("or into direct byte wrong");
   or_dir_imm_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_OR &&
      cmd_i.form == bal_pkg::BAL_F_DIR_IMM
      |=> !wr_o.en ##1 wr_o.en && wr_o.data == $past(cmd_i.src | cmd_i.imm, 2))
      else $error("or immediate into direct wrong");
   xor_acc_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_XOR &&
      cmd_i.form == bal_pkg::BAL_F_DIR
      |=> done_o && len_o == `BAL_LEN_TWO && acc_o == $past(acc_o ^ cmd_i.src))
      else $error("xor into accumulator wrong");
   muldiv_time_a: assert property (accept &&
      cmd_i.op inside {bal_pkg::BAL_OP_MUL, bal_pkg::BAL_OP_DIV}
      |=> (!cmd_ready && !done_o) [*3] ##1 done_o && len_o == `BAL_LEN_ONE)
      else $error("multiply or divide timing wrong");
   ptr_inc_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_INC_PTR
      |=> !done_o ##1 done_o && ptr_o == 16'($past(ptr_o, 2) + `BAL_PTR_STEP))
      else $error("pointer increment wrong");
   bcd_keep_a: assert property (accept && cmd_i.op == bal_pkg::BAL_OP_BCD &&
      !ac_o && !cy_o && acc_o[3:0] <= `BAL_BCD_LIMIT && acc_o[7:4] <= `BAL_BCD_LIMIT
      |=> done_o && len_o == `BAL_LEN_ONE && acc_o == $past(acc_o))
      else $error("bcd correction changed valid digits");
   mul_seen_c: cover property (accept && cmd_i.op == bal_pkg::BAL_OP_MUL ##4 done_o);
   div_zero_c: cover property (accept && cmd_i.op == bal_pkg::BAL_OP_DIV && b_o == `BAL_BYTE_RST);
   bcd_fix_c:  cover property (accept && cmd_i.op == bal_pkg::BAL_OP_BCD ##1 cy_o);
   dir_imm_c:  cover property (accept && cmd_i.form == bal_pkg::BAL_F_DIR_IMM ##2 wr_o.en);
endmodule

// ===== dv/bal_ram_model.sv
// Internal RAM model: supplies operand bytes and stores direct write-backs
`timescale 1ns/1ps
module bal_ram_model
(
   // Clock
   input  wire logic             ref_clk,
   // Operand fetch
   input  wire logic [7:0]       addr_i,
   output logic [7:0]            src_o,
   // Write-back
   input  wire bal_pkg::bal_wr_t wr_i
);
   logic [7:0] mem_q [256];
   // Known fill so the bench can predict every operand
   initial
      for (int i = 0; i < 256; i++)
         mem_q[i] = 8'(i) ^ 8'ha5;
   // Store a byte on each write pulse
   always @(posedge ref_clk)
      if (wr_i.en)
         mem_q[wr_i.addr] <= wr_i.data;
   // Operand byte as fetched by the decoder
   assign src_o = mem_q[addr_i];
endmodule

// ===== dv/byte_alu_arith_logic_ops_tb.sv
// Self-checking bench for the byte ALU execution unit
`timescale 1ns/1ps
module byte_alu_arith_logic_ops_tb;
   logic               ref_clk, rst_n, cmd_valid, cmd_ready, done_o, cy_o, ac_o, ov_o;
   logic [1:0]         len_o;
   logic [7:0]         acc_o, b_o, c_addr, c_imm, src_w, m_acc;
   logic [15:0]        ptr_o;
   logic               m_cy, m_ac, m_ov;
   logic [7:0]         shadow [256];
   bal_pkg::bal_op_t   c_op;
   bal_pkg::bal_form_t c_form;
   bal_pkg::bal_wr_t   wr_o;
   bal_pkg::bal_cmd_t  cmd_i;
   int                 error_cnt, tests_run;
   bal_pkg::bal_form_t forms [6] = '{bal_pkg::BAL_F_REG, bal_pkg::BAL_F_DIR, bal_pkg::BAL_F_IND,
      bal_pkg::BAL_F_IMM, bal_pkg::BAL_F_DIR_ACC, bal_pkg::BAL_F_DIR_IMM};
   // Decoder side: operand byte comes from the RAM model
   assign cmd_i = '{op: c_op, form: c_form, addr: c_addr, src: src_w, imm: c_imm};
   bal_exec bal_exec_inst (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_i(cmd_i), .done_o(done_o), .len_o(len_o), .wr_o(wr_o), .acc_o(acc_o), .b_o(b_o),
      .cy_o(cy_o), .ac_o(ac_o), .ov_o(ov_o), .ptr_o(ptr_o));
   bal_ram_model bal_ram_model_inst (.ref_clk(ref_clk), .addr_i(c_addr), .src_o(src_w), .wr_i(wr_o));
   // Clock
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("Checks %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Offer one command, wait for completion, judge cycles and length
   task automatic issue(bal_pkg::bal_op_t op, bal_pkg::bal_form_t f, logic [7:0] a, logic [7:0] im,
                        int ec, logic [1:0] el);
      int n;
      @(posedge ref_clk);
      #1;
      c_op = op;
      c_form = f;
      c_addr = a;
      c_imm = im;
      cmd_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'b0;
      n = 1;
      while (done_o !== 1'b1 && n < 8)
      begin
         chk("cmd_ready", 1'b0, cmd_ready);
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (done_o !== 1'b1)
      begin
         chk("done_o", 1'b1, done_o);
         complete_run();
      end
      chk("cycles", 16'(ec), 16'(n));
      chk("len_o", el, len_o);
   endtask
   // Reference model of add, subtract, logic, increment and decrement
   task automatic run(bal_pkg::bal_op_t op, bal_pkg::bal_form_t f, logic [7:0] a, logic [7:0] im);
      logic [8:0] r;
      logic [7:0] l, o;
      logic       ci, mem, ar;
      l = m_acc;
      o = (f == bal_pkg::BAL_F_IMM) ? im : shadow[a];
      mem = f inside {bal_pkg::BAL_F_DIR_ACC, bal_pkg::BAL_F_DIR_IMM};
      if (mem)
      begin
         l = shadow[a];
         o = (f == bal_pkg::BAL_F_DIR_ACC) ? m_acc : im;
      end
      if (op inside {bal_pkg::BAL_OP_INC, bal_pkg::BAL_OP_DEC} && f != bal_pkg::BAL_F_ACC)
      begin
         l = shadow[a];
         mem = 1'b1;
      end
      ci = (op == bal_pkg::BAL_OP_ADD) ? 1'b0 : m_cy;
      ar = op inside {bal_pkg::BAL_OP_ADD, bal_pkg::BAL_OP_ADD_WITH_CARRY_OP, bal_pkg::BAL_OP_SUBTRACT_WITH_BORROW_OP};
      case (op)
         bal_pkg::BAL_OP_AND: r = {1'b0, l & o};
         bal_pkg::BAL_OP_OR:  r = {1'b0, l | o};
         bal_pkg::BAL_OP_XOR: r = {1'b0, l ^ o};
         bal_pkg::BAL_OP_INC: r = {1'b0, l + 8'h01};
         bal_pkg::BAL_OP_DEC: r = {1'b0, l - 8'h01};
         bal_pkg::BAL_OP_SUBTRACT_WITH_BORROW_OP:
         begin
            r = {1'b0, l} - {1'b0, o} - {8'h00, ci};
            m_ac = 5'(l[3:0]) < 5'(o[3:0]) + 5'(ci);
            m_ov = (l[7] ^ o[7]) & (r[7] ^ l[7]);
         end
         default:
         begin
            r = {1'b0, l} + {1'b0, o} + {8'h00, ci};
            m_ac = 5'(l[3:0]) + 5'(o[3:0]) + 5'(ci) > 5'h0f;
            m_ov = ~(l[7] ^ o[7]) & (r[7] ^ l[7]);
         end
      endcase
      if (ar)
         m_cy = r[8];
      issue(op, f, a, im, (f == bal_pkg::BAL_F_DIR_IMM) ? 2 : 1, (f == bal_pkg::BAL_F_DIR_IMM) ? 2'h3 :
            (f inside {bal_pkg::BAL_F_DIR, bal_pkg::BAL_F_IMM, bal_pkg::BAL_F_DIR_ACC}) ? 2'h2 : 2'h1);
      chk("wr_en", mem, wr_o.en);
      if (mem)
      begin
         shadow[a] = r[7:0];
         chk("wr_addr", a, wr_o.addr);
         chk("wr_data", r[7:0], wr_o.data);
      end
      else
         m_acc = r[7:0];
      chk("acc_o", m_acc, acc_o);
      chk("cy_o", m_cy, cy_o);
      if (ar)
      begin
         chk("ac_o", m_ac, ac_o);
         chk("ov_o", m_ov, ov_o);
      end
   endtask
   // Load the accumulator with logic ops, which leave the flags alone
   task automatic set_acc(logic [7:0] v);
      run(bal_pkg::BAL_OP_AND, bal_pkg::BAL_F_IMM, 8'h00, 8'h00);
      run(bal_pkg::BAL_OP_OR, bal_pkg::BAL_F_IMM, 8'h00, v);
   endtask
   task automatic t_arith();
      bal_pkg::bal_op_t ops [3] = '{bal_pkg::BAL_OP_ADD, bal_pkg::BAL_OP_ADD_WITH_CARRY_OP, bal_pkg::BAL_OP_SUBTRACT_WITH_BORROW_OP};
      logic [7:0]       im;
      foreach (ops[i])
      begin
         set_acc(8'hff);
         run(bal_pkg::BAL_OP_ADD, bal_pkg::BAL_F_IMM, 8'h00, 8'h01);
         for (int k = 0; k < 4; k++)
         begin
            im = 8'h9c - 8'(4 * i + k);
            run(ops[i], forms[k], 8'h30 + 8'(k), im);
         end
      end
   endtask
   task automatic t_logic();
      bal_pkg::bal_op_t ops [3] = '{bal_pkg::BAL_OP_AND, bal_pkg::BAL_OP_OR, bal_pkg::BAL_OP_XOR};
      logic [7:0]       im;
      set_acc(8'h5b);
      foreach (ops[i])
         foreach (forms[k])
         begin
            im = 8'h3c ^ 8'(i * k + 5);
            run(ops[i], forms[k], 8'h40 + 8'(k), im);
         end
   endtask
   task automatic t_incdec();
      set_acc(8'h00);
      run(bal_pkg::BAL_OP_DEC, bal_pkg::BAL_F_ACC, 8'h00, 8'h00);
      run(bal_pkg::BAL_OP_INC, bal_pkg::BAL_F_ACC, 8'h00, 8'h00);
      for (int k = 0; k < 3; k++)
      begin
         run(bal_pkg::BAL_OP_INC, forms[k], 8'h50 + 8'(k), 8'h00);
         run(bal_pkg::BAL_OP_DEC, forms[k], 8'h50 + 8'(k), 8'h00);
      end
      issue(bal_pkg::BAL_OP_INC_PTR, bal_pkg::BAL_F_ACC, 8'h00, 8'h00, 2, 2'h1);
      chk("ptr_o", 16'h0001, ptr_o);
   endtask
   task automatic t_muldiv();
      set_acc(8'h37);
      issue(bal_pkg::BAL_OP_MUL, bal_pkg::BAL_F_ACC, 8'h00, 8'h00, 4, 2'h1);
      chk("acc_o", 8'h00, acc_o);
      chk("b_o", 8'h00, b_o);
      chk("ov_o", 1'b0, ov_o);
      m_acc = 8'h00;
      m_cy = 1'b0;
      set_acc(8'h37);
      issue(bal_pkg::BAL_OP_DIV, bal_pkg::BAL_F_ACC, 8'h00, 8'h00, 4, 2'h1);
      chk("acc_o", 8'h37, acc_o);
      chk("ov_o", 1'b1, ov_o);
      chk("cy_o", 1'b0, cy_o);
   endtask
   task automatic t_bcd();
      set_acc(8'h19);
      run(bal_pkg::BAL_OP_ADD, bal_pkg::BAL_F_IMM, 8'h00, 8'h28);
      issue(bal_pkg::BAL_OP_BCD, bal_pkg::BAL_F_ACC, 8'h00, 8'h00, 1, 2'h1);
      chk("acc_o", 8'h47, acc_o);
      set_acc(8'h99);
      run(bal_pkg::BAL_OP_ADD, bal_pkg::BAL_F_IMM, 8'h00, 8'h01);
      issue(bal_pkg::BAL_OP_BCD, bal_pkg::BAL_F_ACC, 8'h00, 8'h00, 1, 2'h1);
      chk("acc_o", 8'h00, acc_o);
      chk("cy_o", 1'b1, cy_o);
      m_acc = 8'h00;
      m_cy = 1'b1;
      // Valid digits with both carries clear must pass through untouched
      set_acc(8'h12);
      run(bal_pkg::BAL_OP_ADD, bal_pkg::BAL_F_IMM, 8'h00, 8'h34);
      issue(bal_pkg::BAL_OP_BCD, bal_pkg::BAL_F_ACC, 8'h00, 8'h00, 1, 2'h1);
      chk("acc_o", 8'h46, acc_o);
      chk("cy_o", 1'b0, cy_o);
   endtask
   // Two single-cycle adds taken on consecutive edges
   task automatic t_b2b();
      set_acc(8'h10);
      @(posedge ref_clk);
      #1;
      c_op = bal_pkg::BAL_OP_ADD;
      c_form = bal_pkg::BAL_F_IMM;
      c_imm = 8'h01;
      cmd_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      c_imm = 8'h02;
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'b0;
      chk("done_o", 1'b1, done_o);
      chk("acc_o", 8'h13, acc_o);
      m_acc = 8'h13;
   endtask
   // Reset, then each scenario in turn
   initial
   begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      c_op = bal_pkg::BAL_OP_ADD;
      c_form = bal_pkg::BAL_F_REG;
      c_addr = 8'h00;
      c_imm = 8'h00;
      {m_acc, m_cy, m_ac, m_ov} = '0;
      for (int i = 0; i < 256; i++)
         shadow[i] = 8'(i) ^ 8'ha5;
      repeat (12) @(posedge ref_clk);
      #1;
      chk("cmd_ready", 1'b1, cmd_ready);
      chk("acc_o", 8'h00, acc_o);
      chk("ptr_o", 16'h0000, ptr_o);
      rst_n = 1'b1;
      t_arith();
      t_logic();
      t_incdec();
      t_muldiv();
      t_bcd();
      t_b2b();
      complete_run();
   end
endmodule
